//--- hdl/serial_command_port_defines.svh
`ifndef SERIAL_COMMAND_PORT_DEFINES_SVH
`define SERIAL_COMMAND_PORT_DEFINES_SVH
`define BYTE_BITS 8
`define MIN_EDGES 5'd8
`define RESET_EDGES 5'd16
`define CNT_MAX 5'd31
`define CMD_SOFT_RESET 8'h02
`define CMD_HARD_RESET 8'h04
`define CMD_CHAN_WRITE 8'h4a
`define CMD_CHAN_READ 8'h4b
`define FRAME_ALT_COUNT 2'd2
`define CHAN_ON_RESET 4'hf
`define IDLE_BYTE 8'h00
`endif

//--- hdl/serial_command_port_pkg.sv
package serial_command_port_pkg;
  typedef enum logic [1:0] {
    st_command,
    st_write_data,
    st_read_data
  } port_state_type;
endpackage : serial_command_port_pkg

//--- hdl/serial_command_port.sv
`include "serial_command_port_defines.svh"
module serial_command_port
  import serial_command_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic select_n_pin,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic frame_sync_pulse,
  // command engine side
  input wire logic [3:0] data_len,
  input wire logic [7:0] read_data_ch0,
  input wire logic [7:0] read_data_ch1,
  input wire logic [7:0] read_data_ch2,
  input wire logic [7:0] read_data_ch3,
  output logic [7:0] command_byte,
  output logic command_strobe,
  output logic [7:0] write_byte,
  output logic [3:0] write_strobe,
  output logic [3:0] soft_reset_strobe,
  output logic hard_reset_strobe,
  output logic [3:0] channel_on_register,
  output logic alternate_mode
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [2:0] cs_sync_reg, ck_sync_reg, frame_sync_reg;
  logic [1:0] di_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      ck_sync_reg <= 3'h7;
      frame_sync_reg <= 3'h0;
      di_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], select_n_pin};
      ck_sync_reg <= {ck_sync_reg[1:0], serial_shift_clock};
      frame_sync_reg <= {frame_sync_reg[1:0], frame_sync_pulse};
      di_sync_reg <= {di_sync_reg[0], serial_data_in};
    end
  end
  logic cs_low, cs_fall, cs_rise, ck_rise, ck_fall, ck_edge, frame_rise;
  assign cs_low = !cs_sync_reg[1];
  assign cs_fall = cs_sync_reg[2] && !cs_sync_reg[1];
  assign cs_rise = !cs_sync_reg[2] && cs_sync_reg[1];
  // edges only count inside a select window
  assign ck_rise = cs_low && !ck_sync_reg[2] && ck_sync_reg[1];
  assign ck_fall = cs_low && ck_sync_reg[2] && !ck_sync_reg[1];
  assign ck_edge = ck_sync_reg[2] != ck_sync_reg[1];
  assign frame_rise = !frame_sync_reg[2] && frame_sync_reg[1];
  // ----------------------------------------
  // link state
  // ----------------------------------------
  port_state_type state_reg, state_next;
  logic [7:0] shift_reg, shift_next, out_reg, out_next;
  logic [4:0] edge_reg, edge_next;
  logic [3:0] left_reg, left_next, chan_reg, chan_next;
  logic [7:0] cmd_reg, cmd_next, wbyte_reg, wbyte_next;
  logic cmd_stb_next, cmd_stb_reg, hard_next, hard_reg;
  logic [3:0] wstb_next, wstb_reg, soft_next, soft_reg;
  logic dout_reg, dout_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] frame_cnt_reg, frame_cnt_next;
  logic static_reg, static_next, alt_reg, alt_next;
  logic [7:0] rd_sel;
  // lowest-numbered enabled channel wins a read
  always_comb begin
    rd_sel = `IDLE_BYTE;
    if (chan_reg[0]) rd_sel = read_data_ch0;
    else if (chan_reg[1]) rd_sel = read_data_ch1;
    else if (chan_reg[2]) rd_sel = read_data_ch2;
    else if (chan_reg[3]) rd_sel = read_data_ch3;
  end
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    out_next = out_reg;
    edge_next = edge_reg;
    left_next = left_reg;
    chan_next = chan_reg;
    cmd_next = cmd_reg;
    wbyte_next = wbyte_reg;
    cmd_stb_next = 1'b0;
    hard_next = 1'b0;
    wstb_next = 4'h0;
    soft_next = 4'h0;
    dout_next = dout_reg;
    bit_next = bit_reg;
    frame_cnt_next = frame_cnt_reg;
    static_next = static_reg;
    alt_next = alt_reg;
    if (cs_fall) begin
      edge_next = 5'd0;
      frame_cnt_next = 2'd0;
      static_next = 1'b1;
      bit_next = 3'd7;
      dout_next = out_reg[7];
    end
    if (ck_rise) begin
      shift_next = {shift_reg[6:0], di_sync_reg[1]};
      if (edge_reg != `CNT_MAX) edge_next = edge_reg + 5'd1;
    end
    // a fall before the first rise of a window would skip the msb
    if (ck_fall && !cs_fall && edge_reg != 5'd0 &&
        state_reg == st_read_data) begin
      bit_next = bit_reg - 3'd1;
      dout_next = out_reg[bit_next];
    end
    if (cs_low && ck_edge) static_next = 1'b0;
    if (cs_low && frame_rise && static_reg &&
        frame_cnt_reg != `FRAME_ALT_COUNT)
      frame_cnt_next = frame_cnt_reg + 2'd1;
    if (frame_cnt_reg == `FRAME_ALT_COUNT && static_reg)
      alt_next = 1'b1;
    if (cs_rise) begin
      if (edge_reg >= `RESET_EDGES) begin
        hard_next = 1'b1;
        state_next = st_command;
        left_next = 4'd0;
        chan_next = `CHAN_ON_RESET;
      end else if (edge_reg >= `MIN_EDGES) begin
        unique case (state_reg)
          st_command: begin
            cmd_next = shift_reg;
            cmd_stb_next = 1'b1;
            if (shift_reg == `CMD_HARD_RESET) begin
              hard_next = 1'b1;
              chan_next = `CHAN_ON_RESET;
            end else if (shift_reg == `CMD_SOFT_RESET)
              soft_next = chan_reg;
            else if (data_len != 4'd0) begin
              left_next = data_len;
              if (shift_reg[0]) begin
                state_next = st_read_data;
                out_next = (shift_reg == `CMD_CHAN_READ) ?
                  {4'h0, chan_reg} : rd_sel;
              end else
                state_next = st_write_data;
            end
          end
          st_write_data: begin
            wbyte_next = shift_reg;
            if (cmd_reg == `CMD_CHAN_WRITE)
              chan_next = shift_reg[3:0];
            else
              wstb_next = chan_reg;
            left_next = left_reg - 4'd1;
            if (left_reg == 4'd1) state_next = st_command;
          end
          st_read_data: begin
            left_next = left_reg - 4'd1;
            out_next = rd_sel;
            if (left_reg == 4'd1) state_next = st_command;
          end
          default: state_next = st_command;
        endcase
      end
    end
  end
  // short windows decode nothing, though a static one can still set alternate mode; idle clocks are harmless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_command;
      shift_reg <= `IDLE_BYTE;
      out_reg <= `IDLE_BYTE;
      edge_reg <= 5'd0;
      left_reg <= 4'd0;
      chan_reg <= `CHAN_ON_RESET;
      cmd_reg <= `IDLE_BYTE;
      wbyte_reg <= `IDLE_BYTE;
      cmd_stb_reg <= 1'b0;
      hard_reg <= 1'b0;
      wstb_reg <= 4'h0;
      soft_reg <= 4'h0;
      dout_reg <= 1'b0;
      bit_reg <= 3'd7;
      frame_cnt_reg <= 2'd0;
      static_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      out_reg <= out_next;
      edge_reg <= edge_next;
      left_reg <= left_next;
      chan_reg <= chan_next;
      cmd_reg <= cmd_next;
      wbyte_reg <= wbyte_next;
      cmd_stb_reg <= cmd_stb_next;
      hard_reg <= hard_next;
      wstb_reg <= wstb_next;
      soft_reg <= soft_next;
      dout_reg <= dout_next;
      bit_reg <= bit_next;
      frame_cnt_reg <= frame_cnt_next;
      static_reg <= static_next;
      alt_reg <= alt_next;
    end
  end
  assign serial_data_out = dout_reg;
  assign serial_data_oe = cs_low && state_reg == st_read_data;
  assign command_byte = cmd_reg;
  assign command_strobe = cmd_stb_reg;
  assign write_byte = wbyte_reg;
  assign write_strobe = wstb_reg;
  assign soft_reset_strobe = soft_reg;
  assign hard_reset_strobe = hard_reg;
  assign channel_on_register = chan_reg;
  assign alternate_mode = alt_reg;
endmodule : serial_command_port

//--- verification/serial_command_port_asserts.sv
module serial_command_port_asserts (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_n_pin,
  input wire logic serial_data_oe,
  input wire logic command_strobe,
  input wire logic [3:0] write_strobe,
  input wire logic [3:0] soft_reset_strobe,
  input wire logic hard_reset_strobe,
  input wire logic [3:0] channel_on_register,
  input wire logic alternate_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // idle select, long enough to clear the synchroniser
  // ----
  sequence sel_idle;
    select_n_pin [*6];
  endsequence
  chk_idle_quiet: assert property (sel_idle |-> !command_strobe)
    else $error("decode while deselected");
  chk_idle_nodrive: assert property (sel_idle |-> !serial_data_oe)
    else $error("line driven while deselected");
  chk_cmd_pulse: assert property (command_strobe |=> !command_strobe)
    else $error("command strobe too long");
  chk_cmd_close: assert property (
      command_strobe |-> $past(select_n_pin, 3))
    else $error("command taken before window closed");
  chk_hard_chan: assert property (
      hard_reset_strobe |-> ##[0:1] channel_on_register == 4'hf)
    else $error("hard reset kept enables");
  chk_soft_en: assert property (
      soft_reset_strobe != 4'h0 |-> soft_reset_strobe == channel_on_register)
    else $error("soft reset hit wrong channels");
  chk_write_fan: assert property (
      write_strobe != 4'h0 && $stable(channel_on_register) |->
      write_strobe == channel_on_register)
    else $error("write reached wrong channels");
  chk_alt_sticky: assert property (alternate_mode |=> alternate_mode)
    else $error("alternate mode dropped");
endmodule : serial_command_port_asserts

bind serial_command_port serial_command_port_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .select_n_pin(select_n_pin),
  .serial_data_oe(serial_data_oe), .command_strobe(command_strobe),
  .write_strobe(write_strobe), .soft_reset_strobe(soft_reset_strobe),
  .hard_reset_strobe(hard_reset_strobe),
  .channel_on_register(channel_on_register), .alternate_mode(alternate_mode)
);

//--- verification/serial_host_model.sv
module serial_host_model (
  // bench side
  input wire logic clk,
  input wire logic line,
  // pins towards the port
  output logic select_n = 1'b1,
  output logic sck = 1'b1,
  output logic dat = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one byte per window; extra leading edges carry noise bits
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    @(posedge clk) select_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) sck <= 1'b0;
      dat <= (i < n - 8) ? 1'($urandom) : b[n - 1 - i];
      repeat (3) @(posedge clk);
      @(posedge clk) sck <= 1'b1;
      repeat (3) @(posedge clk);
      r = {r[6:0], line};
    end
    @(posedge clk) select_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : xfer
  // shift clock running, then resting low, all while deselected
  task automatic spin(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) sck <= 1'b0;
      repeat (3) @(posedge clk);
      @(posedge clk) sck <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk) sck <= 1'b0;
    repeat (4 * n) @(posedge clk);
    sck <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : spin
  // select low with the shift clock resting
  task automatic hold(input int n);
    @(posedge clk) select_n <= 1'b0;
    repeat (n) @(posedge clk);
    select_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : hold
endmodule : serial_host_model

//--- verification/serial_command_port_tb.sv
module serial_command_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, frame = 1'b0, sel_n, sck, hdat, dout;
  logic doe, cstb, hstb, alt;
  logic [3:0] dlen = 4'h0, en, wstb, sstb, chans, last_ws = 4'h0;
  logic [3:0] last_ss = 4'h0;
  logic [7:0] rd[4] = '{default: 8'h00};
  logic [7:0] cbyte, wbyte, rx, d;
  localparam logic [7:0] shared_cfg = 8'h25;
  int errors = 0, n_compared = 0, ncmd = 0, nhard = 0, cyc = 0, n, c;
  wire line = doe ? dout : hdat;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    frame <= (cyc % 64) == 0;
    if (cstb) ncmd <= ncmd + 1;
    if (hstb) nhard <= nhard + 1;
    if (wstb != 4'h0) last_ws <= wstb;
    if (sstb != 4'h0) last_ss <= sstb;
  end
  serial_host_model h (.clk(clk), .line(line), .select_n(sel_n), .sck(sck),
    .dat(hdat));
  serial_command_port u_dut (.clk(clk), .rst_n(rst_n), .select_n_pin(sel_n),
    .serial_shift_clock(sck), .serial_data_in(line), .serial_data_out(dout),
    .serial_data_oe(doe), .frame_sync_pulse(frame), .data_len(dlen),
    .read_data_ch0(rd[0]), .read_data_ch1(rd[1]), .read_data_ch2(rd[2]),
    .read_data_ch3(rd[3]), .command_byte(cbyte), .command_strobe(cstb),
    .write_byte(wbyte), .write_strobe(wstb), .soft_reset_strobe(sstb),
    .hard_reset_strobe(hstb), .channel_on_register(chans),
    .alternate_mode(alt));
  function automatic int lowest(input logic [3:0] e);
    for (int i = 3; i >= 0; i--) if (e[i]) lowest = i;
  endfunction : lowest
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check
  task automatic cmd(input logic [7:0] c, input logic [3:0] len, input int e);
    dlen <= len;
    h.xfer(c, e, rx);
  endtask : cmd
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    #2ms;
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h04c394d2));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(chans === 4'hf, "enable reset value");
    for (int k = 0; k < 4; k++) begin
      en = 4'($urandom_range(15, 1));
      cmd(8'h4a, 4'h1, 8);
      h.xfer({4'h0, en}, 8, rx);
      check(chans === en, "enable write");
      cmd(8'h4b, 4'h1, 8);
      h.xfer(8'h00, 8, rx);
      check(rx[3:0] === en, "enable read back");
      foreach (rd[i]) rd[i] <= 8'($urandom);
      cmd(8'h53, 4'h2, 8);
      n = ncmd;
      h.xfer(8'h02, 8, rx);
      check(rx === rd[lowest(en)], "lowest channel read");
      h.xfer(8'h02, 8, rx);
      check(ncmd === n, "decode during read");
      check(rx === rd[lowest(en)], "second read byte");
      d = 8'($urandom);
      cmd(8'h52, 4'h1, 8 + 2 * k);
      check(cbyte === 8'h52, "command byte");
      h.xfer(d, 8, rx);
      check(last_ws === en && wbyte === d, "broadcast write");
      cmd(8'h02, 4'h0, 8);
      check(last_ss === en, "soft reset channels");
      $display("test %0d done", k);
    end
    c = $urandom_range(3, 0);
    cmd(8'h4a, 4'h1, 8);
    h.xfer(8'h01 << c, 8, rx);
    cmd(8'h53, 4'h1, 8);
    h.xfer(8'h00, 8, rx);
    check(rx === rd[c], "single channel read");
    cmd(8'h44, 4'h1, 8);
    h.xfer(shared_cfg, 8, rx);
    check(wbyte === shared_cfg && last_ws === 4'h1 << c, "shared write");
    n = ncmd;
    h.spin(20);
    check(ncmd === n && chans === 4'h1 << c, "idle shift clock");
    h.xfer(8'h02, 7, rx);
    check(ncmd === n, "short window");
    check(alt === 1'b0, "early alternate mode");
    n = nhard;
    h.xfer(8'h00, 16, rx);
    check(chans === 4'hf && nhard === n + 1, "long window reset");
    cmd(8'h4a, 4'h1, 8);
    h.xfer(8'h01 << c, 8, rx);
    n = nhard;
    cmd(8'h04, 4'h0, 8);
    check(chans === 4'hf && nhard === n + 1, "hard reset command");
    h.hold(200);
    check(alt === 1'b1, "alternate mode");
    $display("corner tests done");
    close_out();
  end
endmodule : serial_command_port_tb
